// ---- src/amp_key_cfg.svh ----
// Offsets, field positions, reset values and timing counts for the amplitude keying block.
`ifndef AMP_KEY_CFG_SVH
`define AMP_KEY_CFG_SVH

// ----------------------------------------------------------------------------
// Programming port offsets
// ----------------------------------------------------------------------------
`define AK_ADDR_PWR      6'h1d
`define AK_ADDR_CTL      6'h20
`define AK_ADDR_MAN_HI   6'h21
`define AK_ADDR_MAN_LO   6'h22
`define AK_ADDR_RATE     6'h25
`define AK_ADDR_AUX_HI   6'h26
`define AK_ADDR_AUX_LO   6'h27

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AK_BIT_MAIN_DAC_POWERDOWN 4
`define AK_BIT_SINC_BYP  6
`define AK_BIT_MULT_EN   5
`define AK_BIT_RAMP_INT  4

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define AK_RST_PWR       8'h00
`define AK_RST_CTL       8'h00
`define AK_RST_WORD      12'h000
`define AK_RST_RATE      8'h00
`define AK_RATE_MIN      8'h03
`define AK_STEP_MAX      12'hfff
`define AK_STEP_ZERO     12'h000

`endif

// ---- src/amp_key_pkg.sv ----
// Types shared by the amplitude keying block.
package amp_key_pkg;

   // Ramp-rate counter phases.
   typedef enum logic [1:0] {
      RR_STALL = 2'b00,
      RR_LOAD  = 2'b01,
      RR_COUNT = 2'b10
   } rate_state_e;

   // Twelve-bit amplitude or sample word.
   typedef logic [11:0] word12_t;

endpackage

// ---- src/amplitude_shaped_keying.sv ----
// Amplitude path of the synthesizer: keying ramp, multiplier, sinc filter, DACs.
`timescale 1ns/1ns
`default_nettype none
`include "amp_key_cfg.svh"

module amplitude_shaped_keying (
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   input  wire logic                prog_wr,
   input  wire logic [5:0]          prog_addr,
   input  wire logic [7:0]          prog_wdata,
   output var  logic [7:0]          prog_rdata,
   input  wire logic                buffer_transfer_strobe,
   input  wire logic                shape_key_pin,
   input  wire logic signed [11:0]  cos_sample,
   output var  logic signed [11:0]  cos_dac_data,
   output var  logic                cos_dac_powerdown,
   output var  logic signed [11:0]  aux_dac_data,
   output var  logic [11:0]         ramp_factor
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   // Buffer copies written by the programming port.
   logic [7:0]                pwr_buf_q;
   logic [7:0]                ctl_buf_q;
   amp_key_pkg::word12_t      man_buf_q;
   logic [7:0]                rate_buf_q;
   amp_key_pkg::word12_t      aux_buf_q;
   // Active copies that steer the logic.
   logic [7:0]                pwr_q;
   logic [7:0]                ctl_q;
   amp_key_pkg::word12_t      man_q;
   logic [7:0]                rate_q;
   amp_key_pkg::word12_t      aux_q;
   // Pin synchronisers.
   logic                      upd_s1_q;
   logic                      upd_s2_q;
   logic                      upd_s3_q;
   logic                      key_s1_q;
   logic                      key_s2_q;
   logic                      upd_edge;
   // Ramp generator.
   amp_key_pkg::rate_state_e  rate_st_q;
   logic [7:0]                rate_cnt_q;
   logic                      stall_c;
   logic                      step_pulse;
   amp_key_pkg::word12_t      step_q;
   logic                      mult_en;
   logic                      ramp_int;
   amp_key_pkg::word12_t      factor_c;
   // Data path.
   logic signed [24:0]        prod_c;
   logic signed [11:0]        mul_q;
   logic signed [11:0]        x1_q;
   logic signed [11:0]        x2_q;
   logic signed [15:0]        sinc_c;

   // Clamp a wide signed value into the DAC range.
   function automatic logic signed [11:0] sat12(input logic signed [15:0] v);
      if (v > 16'sd2047) begin
         sat12 = 12'sh7ff;
      end else if (v < -16'sd2048) begin
         sat12 = 12'sh800;
      end else begin
         sat12 = v[11:0];
      end
   endfunction

   // -------------------------------------------------------------------------
   // Programming port
   // -------------------------------------------------------------------------
   // Writes land in buffer registers only; the logic never sees them directly.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pwr_buf_q  <= `AK_RST_PWR;
         ctl_buf_q  <= `AK_RST_CTL;
         man_buf_q  <= `AK_RST_WORD;
         rate_buf_q <= `AK_RST_RATE;
         aux_buf_q  <= `AK_RST_WORD;
      end else if (prog_wr) begin
         case (prog_addr)
            `AK_ADDR_PWR:    pwr_buf_q <= prog_wdata;
            `AK_ADDR_CTL:    ctl_buf_q <= prog_wdata;
            `AK_ADDR_MAN_HI: man_buf_q[11:8] <= prog_wdata[3:0];
            `AK_ADDR_MAN_LO: man_buf_q[7:0] <= prog_wdata;
            `AK_ADDR_RATE:   rate_buf_q <= prog_wdata;
            `AK_ADDR_AUX_HI: aux_buf_q[11:8] <= prog_wdata[3:0];
            `AK_ADDR_AUX_LO: aux_buf_q[7:0] <= prog_wdata;
            default: begin
            end
         endcase
      end
   end

   // Readback shows the buffer contents; unmapped offsets read zero.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prog_rdata <= 8'h00;
      end else begin
         case (prog_addr)
            `AK_ADDR_PWR:    prog_rdata <= pwr_buf_q;
            `AK_ADDR_CTL:    prog_rdata <= ctl_buf_q;
            `AK_ADDR_MAN_HI: prog_rdata <= {4'h0, man_buf_q[11:8]};
            `AK_ADDR_MAN_LO: prog_rdata <= man_buf_q[7:0];
            `AK_ADDR_RATE:   prog_rdata <= rate_buf_q;
            `AK_ADDR_AUX_HI: prog_rdata <= {4'h0, aux_buf_q[11:8]};
            `AK_ADDR_AUX_LO: prog_rdata <= aux_buf_q[7:0];
            default:         prog_rdata <= 8'h00;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   // Both pins are asynchronous; the third update stage only serves the edge.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         upd_s1_q <= 1'b0;
         upd_s2_q <= 1'b0;
         upd_s3_q <= 1'b0;
         key_s1_q <= 1'b0;
         key_s2_q <= 1'b0;
      end else begin
         upd_s1_q <= buffer_transfer_strobe;
         upd_s2_q <= upd_s1_q;
         upd_s3_q <= upd_s2_q;
         key_s1_q <= shape_key_pin;
         key_s2_q <= key_s1_q;
      end
   end

   assign upd_edge = upd_s2_q & ~upd_s3_q;

   // -------------------------------------------------------------------------
   // Active registers
   // -------------------------------------------------------------------------
   // transfer on strobe.
   // Copying every field on one edge avoids a half-updated configuration.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pwr_q  <= `AK_RST_PWR;
         ctl_q  <= `AK_RST_CTL;
         man_q  <= `AK_RST_WORD;
         rate_q <= `AK_RST_RATE;
         aux_q  <= `AK_RST_WORD;
      end else if (upd_edge) begin
         pwr_q  <= pwr_buf_q;
         ctl_q  <= ctl_buf_q;
         man_q  <= man_buf_q;
         rate_q <= rate_buf_q;
         aux_q  <= aux_buf_q;
      end
   end

   assign mult_en  = ctl_q[`AK_BIT_MULT_EN];
   assign ramp_int = ctl_q[`AK_BIT_RAMP_INT];

   // -------------------------------------------------------------------------
   // Ramp-rate counter
   // -------------------------------------------------------------------------
   // stall below three.
   assign stall_c = (rate_q < `AK_RATE_MIN);

   // down-counter phases.
   // Reloading at zero keeps each period at exactly count plus one edges.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rate_st_q  <= amp_key_pkg::RR_STALL;
         rate_cnt_q <= 8'h00;
      end else if (stall_c) begin
         rate_st_q <= amp_key_pkg::RR_STALL;
      end else begin
         case (rate_st_q)
            // Leaving a stall needs one load edge first.
            amp_key_pkg::RR_STALL: begin
               rate_st_q <= amp_key_pkg::RR_LOAD;
            end
            amp_key_pkg::RR_LOAD: begin
               rate_cnt_q <= rate_q;
               rate_st_q  <= amp_key_pkg::RR_COUNT;
            end
            amp_key_pkg::RR_COUNT: begin
               if (rate_cnt_q == 8'h00) begin
                  rate_cnt_q <= rate_q;
               end else begin
                  rate_cnt_q <= rate_cnt_q - 8'h01;
               end
            end
            default: begin
               rate_st_q <= amp_key_pkg::RR_STALL;
            end
         endcase
      end
   end

   assign step_pulse = (rate_st_q == amp_key_pkg::RR_COUNT)
                     && (rate_cnt_q == 8'h00) && !stall_c;

   // -------------------------------------------------------------------------
   // Step counter
   // -------------------------------------------------------------------------
   // key decides direction.
   // The counter only moves while the internal ramp drives the multiplier.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         step_q <= `AK_STEP_ZERO;
      end else if (step_pulse && mult_en && ramp_int) begin
         // 4095 up steps span all 4096 levels.
         if (key_s2_q && step_q != `AK_STEP_MAX) begin
            step_q <= step_q + 12'h001;
         end else if (!key_s2_q && step_q != `AK_STEP_ZERO) begin
            step_q <= step_q - 12'h001;
         end
      end
   end

   assign factor_c    = ramp_int ? step_q : man_q;
   assign ramp_factor = factor_c;

   // -------------------------------------------------------------------------
   // Multiplier and inverse sinc
   // -------------------------------------------------------------------------
   // scale by factor over 4096.
   assign prod_c = cos_sample * $signed({1'b0, factor_c});

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mul_q <= 12'sh000;
      end else if (mult_en) begin
         mul_q <= prod_c[23:12];
      end else begin
         mul_q <= cos_sample;
      end
   end

   // Three-tap history for the precompensation filter.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         x1_q <= 12'sh000;
         x2_q <= 12'sh000;
      end else begin
         x1_q <= mul_q;
         x2_q <= x1_q;
      end
   end

   // Mild high-frequency lift; a short symmetric kernel keeps phase linear.
   assign sinc_c = 16'(x1_q) + ((16'(x1_q) * 16'sd2 - 16'(mul_q) - 16'(x2_q)) >>> 4);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cos_dac_data      <= 12'sh000;
         cos_dac_powerdown <= 1'b0;
      end else begin
         cos_dac_powerdown <= pwr_q[`AK_BIT_MAIN_DAC_POWERDOWN];
         if (pwr_q[`AK_BIT_MAIN_DAC_POWERDOWN]) begin
            cos_dac_data <= 12'sh000;
         end else if (ctl_q[`AK_BIT_SINC_BYP]) begin
            cos_dac_data <= mul_q;
         end else begin
            cos_dac_data <= sat12(sinc_c);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aux_dac_data <= 12'sh000;
      end else begin
         aux_dac_data <= $signed(aux_q);
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Cycles since the last step pulse, valid once a pulse was seen.
   logic [7:0] since_q;
   logic       seen_q;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         since_q <= 8'h00;
         seen_q  <= 1'b0;
      end else begin
         since_q <= step_pulse ? 8'h00 : since_q + 8'h01;
         seen_q  <= upd_edge ? 1'b0 : (seen_q | step_pulse);
      end
   end

   sequence s_load;
      rate_st_q == amp_key_pkg::RR_LOAD && !stall_c && !upd_edge;
   endsequence
   sequence s_count_from_load;
      ##1 (rate_cnt_q == rate_q) ##1 (stall_c || rate_cnt_q == rate_q - 8'h01);
   endsequence

   a_mult_bypass: assert property (!mult_en |=> mul_q == $past(cos_sample))
      else $error("multiplier not bypassed");
   a_zero_factor: assert property (mult_en && factor_c == 12'h000 |=> mul_q == 12'sh000)
      else $error("zero factor gave nonzero output");
   a_full_factor: assert property (mult_en && factor_c == 12'hfff && cos_sample == 12'sh400
      |=> mul_q == 12'sh3ff)
      else $error("full factor scale wrong");
   a_factor_select: assert property (ramp_int && !upd_edge && !step_pulse
      |=> $stable(ramp_factor))
      else $error("ramp factor moved without a step pulse");
   a_load_then_dec: assert property (s_load |-> s_count_from_load)
      else $error("ramp counter load order wrong");
   a_pulse_interval: assert property (step_pulse && seen_q |-> since_q == rate_q)
      else $error("step pulse interval wrong");
   a_stall_hold: assert property (stall_c |-> !step_pulse ##1 $stable(step_q))
      else $error("stalled counter moved factor");
   a_step_up: assert property (step_pulse && mult_en && ramp_int && key_s2_q
      && step_q != 12'hfff |=> step_q == $past(step_q) + 12'h001)
      else $error("step counter did not increment");
   a_hold_full: assert property (step_q == 12'hfff && key_s2_q |=> step_q == 12'hfff)
      else $error("factor left full scale");
   a_update_only: assert property (!upd_edge |=> $stable(ctl_q) && $stable(rate_q))
      else $error("active register changed without strobe");
   a_pd_silent: assert property (pwr_q[`AK_BIT_MAIN_DAC_POWERDOWN]
      |=> cos_dac_data == 12'sh000)
      else $error("powered-down DAC not silent");
   a_aux_follow: assert property (##1 aux_dac_data == $signed($past(aux_q)))
      else $error("control DAC not refreshed");

endmodule
`default_nettype wire

// ---- dv/amplitude_shaped_keying_tb_top.sv ----
// Self-checking bench for the amplitude keying block.
`timescale 1ns/1ns
`default_nettype none
`include "amp_key_cfg.svh"

// ----------------------------------------------------------------------------
// Compare macro
// ----------------------------------------------------------------------------
// Counts every comparison; case inequality so an unknown never passes.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end

module amplitude_shaped_keying_tb_top;
   logic               sys_clk;                 // System clock, 100 MHz.
   logic               resetn;                  // Asynchronous reset, active low.
   logic               prog_wr;                 // Byte write strobe.
   logic [5:0]         prog_addr;               // Byte offset.
   logic [7:0]         prog_wdata;              // Write byte.
   logic [7:0]         prog_rdata;              // Registered readback.
   logic               buffer_transfer_strobe;  // Buffer-to-active transfer pin.
   logic               shape_key_pin;           // Keying level.
   logic signed [11:0] cos_sample;              // Cosine input sample.
   logic signed [11:0] cos_dac_data;            // Cosine DAC word.
   logic               cos_dac_powerdown;       // Cosine DAC power-down.
   logic signed [11:0] aux_dac_data;            // Control DAC word.
   logic [11:0]        ramp_factor;             // Current multiplier factor.
   logic               alt;                     // Alternate the sample sign each cycle.
   logic [11:0]        held;                    // Factor captured once a stall is in effect.
   int                 bad_count;               // Mismatches.
   int                 n_compared;              // Comparisons made.
   int                 c;                       // Measured interval.
   int                 n;                       // Wait counter.
   logic [11:0]        fac [3] = '{12'h000, 12'h800, 12'hfff};  // Manual factors.
   logic [11:0]        res [3] = '{12'h000, 12'h200, 12'h3ff};  // 0x400 scaled.
   int                 rate [2] = '{5, 3};      // Ramp rates timed on the way down.

   amplitude_shaped_keying dut (
      .sys_clk                (sys_clk),
      .resetn                 (resetn),
      .prog_wr                (prog_wr),
      .prog_addr              (prog_addr),
      .prog_wdata             (prog_wdata),
      .prog_rdata             (prog_rdata),
      .buffer_transfer_strobe (buffer_transfer_strobe),
      .shape_key_pin          (shape_key_pin),
      .cos_sample             (cos_sample),
      .cos_dac_data           (cos_dac_data),
      .cos_dac_powerdown      (cos_dac_powerdown),
      .aux_dac_data           (aux_dac_data),
      .ramp_factor            (ramp_factor)
   );

   // Free-running clock.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Sample source: a constant, or a half-scale sign alternation that the sinc filter boosts.
   always @(negedge sys_clk) begin
      cos_sample <= alt ? -cos_sample : 12'sh400;
   end

   // ----------------------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------------------
   // One byte write; the leading wait keeps back-to-back calls in separate time steps.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      prog_wr = 1'b1;
      prog_addr = a;
      prog_wdata = d;
      @(negedge sys_clk);
      prog_wr = 1'b0;
   endtask

   // A 12-bit word goes as high nibble then low byte.
   task automatic wr12(input logic [5:0] a, input logic [11:0] w);
      wr(a, {4'h0, w[11:8]});
      wr(a + 6'h01, w[7:0]);
   endtask

   // Readback is registered, so it is looked at one cycle after the offset.
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      prog_addr = a;
      @(negedge sys_clk);
      `CHK("readback", e, prog_rdata)
   endtask

   // Three-cycle transfer pulse, then time for sync, update and the datapath.
   task automatic strobe;
      @(negedge sys_clk);
      buffer_transfer_strobe = 1'b1;
      repeat (3) @(negedge sys_clk);
      buffer_transfer_strobe = 1'b0;
      repeat (8) @(negedge sys_clk);
   endtask

   // Cycles until the factor next moves, bounded so a stuck ramp cannot hang.
   task automatic gap(output int k);
      logic [11:0] prev;
      prev = ramp_factor;
      k = 0;
      while (ramp_factor === prev && k < 2000) begin
         @(negedge sys_clk);
         k++;
      end
   endtask

   // Waits bounded for the factor to reach a value; returns the cycles taken.
   task automatic reach(input logic [11:0] v, output int k);
      k = 0;
      while (ramp_factor !== v && k < 20000) begin
         @(negedge sys_clk);
         k++;
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Watchdog: the tests need about 33k cycles, so 80k means a hang.
   initial begin
      #800000;
      bad_count++;
      $display("ERROR watchdog expected done seen hang");
      results();
   end

   // ----------------------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------------------
   initial begin
      bad_count = 0;
      n_compared = 0;
      resetn = 1'b0;
      prog_wr = 1'b0;
      prog_addr = 6'h00;
      prog_wdata = 8'h00;
      buffer_transfer_strobe = 1'b0;
      shape_key_pin = 1'b0;
      cos_sample = 12'sh400;
      alt = 1'b0;
      repeat (6) @(negedge sys_clk);
      resetn = 1'b1;
      // Reset state: buffers clear, control DAC and factor at zero, filter engaged.
      foreach (fac[i]) rd(6'h21 + 6'(i), 8'h00); // word cleared
      rd(`AK_ADDR_PWR, 8'h00); // powered up
      rd(`AK_ADDR_CTL, 8'h00); // filter engaged
      `CHK("aux_reset", 12'h000, aux_dac_data) // word cleared
      `CHK("factor_reset", 12'h000, ramp_factor) // ramp at zero
      alt = 1'b1;
      repeat (8) @(negedge sys_clk);
      `CHK("sinc_on", 12'h500, cos_dac_data[11] ? -cos_dac_data : cos_dac_data) // boost
      $display("test reset done");
      // Buffered writes reach the outputs only after the transfer strobe.
      wr(6'h00, 8'ha5);
      rd(6'h00, 8'h00); // unmapped ignored
      wr(`AK_ADDR_MAN_HI, 8'hff);
      rd(`AK_ADDR_MAN_HI, 8'h0f); // nibble buffered
      wr12(`AK_ADDR_AUX_HI, 12'h800);
      wr(`AK_ADDR_CTL, 8'h40);
      rd(`AK_ADDR_AUX_HI, 8'h08); // word buffered
      `CHK("aux_early", 12'h000, aux_dac_data) // held in buffer
      `CHK("sinc_early", 12'h500, cos_dac_data[11] ? -cos_dac_data : cos_dac_data)
      strobe();
      `CHK("aux_word", 12'h800, aux_dac_data) // most negative code
      `CHK("bypass", 12'h400, cos_dac_data[11] ? -cos_dac_data : cos_dac_data)
      $display("test buffer done");
      // Manual factor: the output is the sample times factor over 4096.
      alt = 1'b0;
      wr(`AK_ADDR_CTL, 8'h60);
      foreach (fac[i]) begin
         wr12(`AK_ADDR_MAN_HI, fac[i]);
         strobe();
         `CHK("man_factor", fac[i], ramp_factor) // user word
         `CHK("scaled", res[i], cos_dac_data) // proportional
      end
      $display("test manual done");
      // Power-down silences the cosine DAC.
      wr(`AK_ADDR_PWR, 8'h10);
      strobe();
      `CHK("pd", 1'b1, cos_dac_powerdown) // powered down
      `CHK("pd_data", 12'h000, cos_dac_data) // no output
      wr(`AK_ADDR_PWR, 8'h00);
      strobe();
      $display("test powerdown done");
      // Internal ramp: full rise at rate three, timed against 4095 steps of four cycles.
      wr(`AK_ADDR_CTL, 8'h70);
      wr(`AK_ADDR_RATE, 8'h03);
      strobe();
      @(negedge sys_clk);
      shape_key_pin = 1'b1;
      reach(12'hfff, n);
      `CHK("rise_time", 1'b1, n >= 16376 && n <= 16392) // full ramp
      repeat (30) @(negedge sys_clk);
      `CHK("full_hold", 12'hfff, ramp_factor) // saturates
      `CHK("full_out", 12'h3ff, cos_dac_data) // ramp drives multiplier
      // Fall: step spacing follows the rate, a low rate stalls, then zero holds.
      shape_key_pin = 1'b0;
      foreach (rate[i]) begin
         wr(`AK_ADDR_RATE, 8'(rate[i]));
         strobe();
         gap(c);
         gap(c);
         `CHK("interval", rate[i] + 1, c) // count plus one
      end
      wr(`AK_ADDR_RATE, 8'h02);
      strobe();
      held = ramp_factor;
      repeat (100) @(negedge sys_clk);
      `CHK("stall", held, ramp_factor) // below three holds
      wr(`AK_ADDR_RATE, 8'h03);
      strobe();
      reach(12'h000, n);
      repeat (30) @(negedge sys_clk);
      `CHK("zero_hold", 12'h000, ramp_factor) // down to zero
      `CHK("zero_out", 12'h000, cos_dac_data) // zero scale
      $display("test ramp done");
      results();
   end
endmodule
`default_nettype wire
